// ===== accel_regs_pkg.sv
// Constants for the acceleration output and event status register group.
// Assumes one 40 MHz reference clock; all users refer to names with ::.

`default_nettype none

package accel_regs_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [6:0] ADDR_STATUS = 7'h1E;
  localparam logic [6:0] ADDR_X_LO = 7'h28;
  localparam logic [6:0] ADDR_X_HI = 7'h29;
  localparam logic [6:0] ADDR_Y_LO = 7'h2A;
  localparam logic [6:0] ADDR_Y_HI = 7'h2B;
  localparam logic [6:0] ADDR_Z_LO = 7'h2C;
  localparam logic [6:0] ADDR_Z_HI = 7'h2D;
  localparam logic [6:0] ADDR_MOTION = 7'h35;
  localparam logic [6:0] ADDR_PROG_LO = 7'h36;
  localparam logic [6:0] ADDR_PROG_HI = 7'h37;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_LONG_COUNTER = 7;
  localparam int BIT_SIG_MOTION = 5;
  localparam int BIT_TILT = 4;
  localparam int BIT_STEP = 3;
  localparam int BIT_SAMPLE_READY = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] SAMPLE_RESET = 16'h0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int STAB_ODR_HZ = 6660;
  localparam int STAB_ODR_CYCLES = CLK_HZ / STAB_ODR_HZ;
  localparam int SPI_BITS = 8;

endpackage

`default_nettype wire

// ===== aux_spi_port.sv
// Auxiliary serial port slave: command byte, then read data bytes.
// Assumes pins from another clock domain; reset is already synchronised.

`default_nettype none

module aux_spi_port (
  input wire logic i_ref_clk, // Reference clock
  input wire logic i_resetn, // Synchronised reset, active low
  input wire logic i_sclk, // Serial clock pin
  input wire logic i_cs_n, // Chip select pin, active low
  input wire logic i_mosi, // Serial data in pin
  input wire logic [7:0] i_rd_data, // Byte at o_addr
  output logic [6:0] o_addr, // Register being addressed
  output logic o_rd_done, // Pulse: byte at o_addr fully shifted
  output logic o_miso, // Serial data out
  output logic o_miso_oe_n // Output enable, low while driving
);

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_d;
    logic [2:0] bit_cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [6:0] addr;
    logic is_read;
    logic in_data;
    logic load;
    logic done;
    logic miso;
  } spi_state_t;

  spi_state_t st_reg;
  spi_state_t st_next;
  logic rise;
  logic fall;

  assign rise = st_reg.sclk_s[1] & ~st_reg.sclk_d;
  assign fall = ~st_reg.sclk_s[1] & st_reg.sclk_d;

  // ****************************************************************
  // Frame decoding
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.sclk_s = {st_reg.sclk_s[0], i_sclk};
    st_next.cs_s = {st_reg.cs_s[0], i_cs_n};
    st_next.mosi_s = {st_reg.mosi_s[0], i_mosi};
    st_next.sclk_d = st_reg.sclk_s[1];
    st_next.load = 1'b0;
    st_next.done = 1'b0;
    if (st_reg.load)
    begin
      st_next.sh_out = i_rd_data;
    end
    if (st_reg.done)
    begin
      st_next.addr = st_reg.addr + 7'h01;
      st_next.load = 1'b1;
    end
    if (st_reg.cs_s[1])
    begin
      st_next.bit_cnt = 3'h0;
      st_next.in_data = 1'b0;
      st_next.is_read = 1'b0;
      st_next.miso = 1'b0;
    end
    else if (rise)
    begin
      st_next.sh_in = {st_reg.sh_in[6:0], st_reg.mosi_s[1]};
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      if (st_reg.bit_cnt == 3'(accel_regs_pkg::SPI_BITS - 1))
      begin
        if (!st_reg.in_data)
        begin
          st_next.addr = {st_reg.sh_in[5:0], st_reg.mosi_s[1]};
          st_next.is_read = st_reg.sh_in[6];
          st_next.in_data = 1'b1;
          st_next.load = st_reg.sh_in[6];
        end
        else
        begin
          st_next.done = st_reg.is_read;
        end
      end
    end
    else if (fall && st_reg.in_data)
    begin
      st_next.miso = st_reg.sh_out[7];
      st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_reg <= '{sclk_s: 2'h3, cs_s: 2'h3, sclk_d: 1'b1, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_addr = st_reg.addr;
  assign o_rd_done = st_reg.done;
  assign o_miso = st_reg.miso;
  assign o_miso_oe_n = st_reg.cs_s[1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_write_no_read;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    !st_reg.is_read |=> !o_rd_done;
  endproperty
  a_write_no_read: assert property (p_write_no_read)
    else $error("write frame produced a read");

endmodule

`default_nettype wire

// ===== accel_output_and_event_status_regs.sv
// Acceleration output and event status registers, two read ports.
// Assumes detection events and chain samples come from logic on
// i_ref_clk; the auxiliary port pins come from outside that domain.

`default_nettype none

module accel_output_and_event_status_regs #(
  parameter int STAB_ODR_CYCLES = accel_regs_pkg::STAB_ODR_CYCLES
) (
  input wire logic i_ref_clk, // 40 MHz reference clock
  input wire logic i_resetn, // Asynchronous reset, active low
  input wire logic i_ui_valid, // Pulse: new user chain sample
  input wire logic [15:0] i_ui_x, // User chain X sample
  input wire logic [15:0] i_ui_y, // User chain Y sample
  input wire logic [15:0] i_ui_z, // User chain Z sample
  input wire logic [15:0] i_stab_x, // Stabilisation chain X
  input wire logic [15:0] i_stab_y, // Stabilisation chain Y
  input wire logic [15:0] i_stab_z, // Stabilisation chain Z
  input wire logic [3:0] i_motion_events, // Pulses: lc, sigmot, tilt, step
  input wire logic [15:0] i_program_events, // Pulses: programs 16..1
  input wire logic i_pri_rd, // Pulse: primary port read
  input wire logic [6:0] i_pri_addr, // Primary port address
  output logic [7:0] o_pri_rd_data, // Primary read byte
  output logic o_pri_rd_valid, // Pulse: o_pri_rd_data valid
  input wire logic i_aux_sclk, // Auxiliary port clock pin
  input wire logic i_aux_cs_n, // Auxiliary port select, active low
  input wire logic i_aux_mosi, // Auxiliary port data in
  output logic o_aux_miso, // Auxiliary port data out
  output logic o_aux_miso_oe_n, // Data out enable, active low
  output logic o_aux_sample_ready // Stabilisation sample ready
);

  typedef struct packed {
    logic [15:0] ui_x;
    logic [15:0] ui_y;
    logic [15:0] ui_z;
    logic [15:0] stab_x;
    logic [15:0] stab_y;
    logic [15:0] stab_z;
    logic [7:0] motion;
    logic [15:0] prog;
    logic aux_ready;
    logic [12:0] odr_cnt;
    logic [7:0] pri_data;
    logic pri_valid;
  } main_state_t;

  main_state_t st_reg;
  main_state_t st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [6:0] aux_addr;
  logic aux_done;
  logic [7:0] aux_rd_data;
  logic stab_tick;
  logic clr_motion;
  logic clr_prog_lo;
  logic clr_prog_hi;
  logic aux_hi_read;
  logic [3:0] motion_keep;
  logic [15:0] prog_next;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // Read multiplexer, source chosen by port
  // ****************************************************************
  function automatic logic [7:0] peek(input logic [6:0] a,
                                      input logic aux,
                                      input main_state_t s);
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [7:0] r;
    x = aux ? s.stab_x : s.ui_x;
    y = aux ? s.stab_y : s.ui_y;
    z = aux ? s.stab_z : s.ui_z;
    r = 8'h00;
    if (a == accel_regs_pkg::ADDR_X_LO)
      r = x[7:0];
    else if (a == accel_regs_pkg::ADDR_X_HI)
      r = x[15:8];
    else if (a == accel_regs_pkg::ADDR_Y_LO)
      r = y[7:0];
    else if (a == accel_regs_pkg::ADDR_Y_HI)
      r = y[15:8];
    else if (a == accel_regs_pkg::ADDR_Z_LO)
      r = z[7:0];
    else if (a == accel_regs_pkg::ADDR_Z_HI)
      r = z[15:8];
    else if (a == accel_regs_pkg::ADDR_MOTION)
      r = s.motion;
    else if (a == accel_regs_pkg::ADDR_PROG_LO)
      r = s.prog[7:0];
    else if (a == accel_regs_pkg::ADDR_PROG_HI)
      r = s.prog[15:8];
    else if (aux && a == accel_regs_pkg::ADDR_STATUS)
      r = {7'h00, s.aux_ready};
    return r;
  endfunction

  assign aux_rd_data = peek(aux_addr, 1'b1, st_reg);

  // ****************************************************************
  // Auxiliary serial port
  // ****************************************************************
  aux_spi_port u_aux_spi (
    .i_ref_clk(i_ref_clk),
    .i_resetn(rst_n),
    .i_sclk(i_aux_sclk),
    .i_cs_n(i_aux_cs_n),
    .i_mosi(i_aux_mosi),
    .i_rd_data(aux_rd_data),
    .o_addr(aux_addr),
    .o_rd_done(aux_done),
    .o_miso(o_aux_miso),
    .o_miso_oe_n(o_aux_miso_oe_n)
  );

  // ****************************************************************
  // Read side effects
  // ****************************************************************
  assign clr_motion = (i_pri_rd && i_pri_addr == accel_regs_pkg::ADDR_MOTION)
                    || (aux_done && aux_addr == accel_regs_pkg::ADDR_MOTION);
  assign clr_prog_lo = (i_pri_rd && i_pri_addr == accel_regs_pkg::ADDR_PROG_LO)
                     || (aux_done
                         && aux_addr == accel_regs_pkg::ADDR_PROG_LO);
  assign clr_prog_hi = (i_pri_rd && i_pri_addr == accel_regs_pkg::ADDR_PROG_HI)
                     || (aux_done
                         && aux_addr == accel_regs_pkg::ADDR_PROG_HI);
  assign aux_hi_read = aux_done
                       && (aux_addr == accel_regs_pkg::ADDR_X_HI
                           || aux_addr == accel_regs_pkg::ADDR_Y_HI
                           || aux_addr == accel_regs_pkg::ADDR_Z_HI);
  assign stab_tick = st_reg.odr_cnt == 13'(STAB_ODR_CYCLES - 1);

  // ****************************************************************
  // Sticky event flags, set wins over clear
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_prog
      if (gi < 8)
      begin : g_lo
        assign prog_next[gi] = i_program_events[gi]
                               | (st_reg.prog[gi] & ~clr_prog_lo);
      end
      else
      begin : g_hi
        assign prog_next[gi] = i_program_events[gi]
                               | (st_reg.prog[gi] & ~clr_prog_hi);
      end
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_motion
      assign motion_keep[gi] = i_motion_events[gi] | ~clr_motion;
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.pri_valid = i_pri_rd;
    if (i_pri_rd)
    begin
      st_next.pri_data = peek(i_pri_addr, 1'b0, st_reg);
    end
    if (i_ui_valid)
    begin
      st_next.ui_x = i_ui_x;
      st_next.ui_y = i_ui_y;
      st_next.ui_z = i_ui_z;
    end
    st_next.odr_cnt = stab_tick ? 13'h0000 : st_reg.odr_cnt + 13'h0001;
    if (stab_tick)
    begin
      st_next.stab_x = i_stab_x;
      st_next.stab_y = i_stab_y;
      st_next.stab_z = i_stab_z;
    end
    st_next.aux_ready = stab_tick | (st_reg.aux_ready & ~aux_hi_read);
    st_next.motion[accel_regs_pkg::BIT_LONG_COUNTER] =
      st_reg.motion[accel_regs_pkg::BIT_LONG_COUNTER] & motion_keep[3]
      | i_motion_events[3];
    st_next.motion[accel_regs_pkg::BIT_SIG_MOTION] =
      st_reg.motion[accel_regs_pkg::BIT_SIG_MOTION] & motion_keep[2]
      | i_motion_events[2];
    st_next.motion[accel_regs_pkg::BIT_TILT] =
      st_reg.motion[accel_regs_pkg::BIT_TILT] & motion_keep[1]
      | i_motion_events[1];
    st_next.motion[accel_regs_pkg::BIT_STEP] =
      st_reg.motion[accel_regs_pkg::BIT_STEP] & motion_keep[0]
      | i_motion_events[0];
    st_next.motion[6] = 1'b0;
    st_next.motion[2:0] = 3'h0;
    st_next.prog = prog_next;
  end

  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '{motion: accel_regs_pkg::FLAGS_RESET,
                  ui_x: accel_regs_pkg::SAMPLE_RESET,
                  ui_y: accel_regs_pkg::SAMPLE_RESET,
                  ui_z: accel_regs_pkg::SAMPLE_RESET,
                  stab_x: accel_regs_pkg::SAMPLE_RESET,
                  stab_y: accel_regs_pkg::SAMPLE_RESET,
                  stab_z: accel_regs_pkg::SAMPLE_RESET,
                  default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_pri_rd_data = st_reg.pri_data;
  assign o_pri_rd_valid = st_reg.pri_valid;
  assign o_aux_sample_ready = st_reg.aux_ready;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ui_load;
    i_ui_valid ##1 !i_ui_valid [*1];
  endsequence

  property p_x_high_read;
    logic [15:0] v;
    (i_ui_valid, v = i_ui_x) ##1 !i_ui_valid ##1 (i_pri_rd
      && i_pri_addr == accel_regs_pkg::ADDR_X_HI)
      |=> o_pri_rd_valid && o_pri_rd_data == v[15:8];
  endproperty
  a_x_high_read: assert property (p_x_high_read)
    else $error("X high byte read wrong");

  property p_y_low_read;
    logic [15:0] v;
    (i_ui_valid, v = i_ui_y) ##1 !i_ui_valid [*2] ##1 (i_pri_rd
      && i_pri_addr == accel_regs_pkg::ADDR_Y_LO)
      |=> o_pri_rd_data == v[7:0];
  endproperty
  a_y_low_read: assert property (p_y_low_read)
    else $error("Y low byte read wrong");

  property p_z_word;
    s_ui_load |-> {st_reg.ui_z} == $past(i_ui_z, 1);
  endproperty
  a_z_word: assert property (p_z_word)
    else $error("Z sample not captured");

  property p_aux_source;
    aux_addr == accel_regs_pkg::ADDR_X_LO |-> aux_rd_data == st_reg.stab_x[7:0];
  endproperty
  a_aux_source: assert property (p_aux_source)
    else $error("auxiliary port not fed from stabilisation chain");

  property p_ready_clear;
    aux_hi_read && !stab_tick |=> !o_aux_sample_ready;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("sample ready not cleared by high byte read");

  property p_ready_set;
    stab_tick |=> o_aux_sample_ready ##1 (st_reg.odr_cnt == 13'h0001);
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("stabilisation tick did not set ready");

  property p_long_counter;
    i_motion_events[3] |=> st_reg.motion[7];
  endproperty
  a_long_counter: assert property (p_long_counter)
    else $error("long counter flag not set");

  property p_sig_motion;
    i_motion_events[2] |=> st_reg.motion[5];
  endproperty
  a_sig_motion: assert property (p_sig_motion)
    else $error("significant motion flag not set");

  property p_tilt;
    i_motion_events[1] |=> st_reg.motion[4];
  endproperty
  a_tilt: assert property (p_tilt)
    else $error("tilt flag not set");

  property p_step;
    i_motion_events[0] |=> st_reg.motion[3];
  endproperty
  a_step: assert property (p_step)
    else $error("step flag not set");

  property p_flag_holds;
    st_reg.motion[7] && !clr_motion |=> st_reg.motion[7];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag lost without a read");

  property p_prog_lo;
    i_program_events[0] ##1 (i_pri_rd
      && i_pri_addr == accel_regs_pkg::ADDR_PROG_LO)
      |=> o_pri_rd_data[0] ##1 !st_reg.prog[0] || $past(i_program_events[0]);
  endproperty
  a_prog_lo: assert property (p_prog_lo)
    else $error("program one flag wrong");

  property p_prog_hi;
    i_program_events[15] |=> st_reg.prog[15];
  endproperty
  a_prog_hi: assert property (p_prog_hi)
    else $error("program sixteen flag not set");

  property p_unused_zero;
    i_pri_rd && i_pri_addr == accel_regs_pkg::ADDR_MOTION
      |=> o_pri_rd_data[6] == 1'b0 && o_pri_rd_data[2:0] == 3'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused flag bit set");

endmodule

`default_nettype wire

// ===== aux_spi_master.sv
// Auxiliary serial port master model: mode 3, MSB first, 200 ns clock.
// Assumes the device shifts out on falling edges after a short delay.

`default_nettype none

module aux_spi_master (
  input wire logic i_miso, // Serial data from the device
  input wire logic i_miso_oe_n, // Device drive enable, active low
  output logic o_sclk, // Serial clock, idles high
  output logic o_cs_n, // Select, active low
  output logic o_mosi, // Serial data to the device
  output logic [7:0] o_byte, // Last data byte received
  output logic o_byte_tog // Toggles once per data byte of a read frame
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_byte = 8'h00;
    o_byte_tog = 1'b0;
  end

  // ****************************************************************
  // Frame: command byte, then n data bytes
  // ****************************************************************
  // Samples at the end of the high phase, well after the device moved.
  task automatic xfer(input logic [7:0] cmd, input int n,
                      input logic [7:0] wr);
    logic [7:0] tx;
    logic [7:0] rx;
    rx = 8'h00;
    o_cs_n = 1'b0;
    #100;
    for (int b = 0; b <= n; b++)
    begin
      tx = (b == 0) ? cmd : wr;
      for (int i = 7; i >= 0; i--)
      begin
        o_sclk = 1'b0;
        o_mosi = tx[i];
        #100;
        o_sclk = 1'b1;
        #100;
        rx[i] = i_miso_oe_n ? ~rx[i] : i_miso;
      end
      if (b > 0 && cmd[7])
      begin
        o_byte = rx;
        o_byte_tog = ~o_byte_tog;
      end
    end
    #200;
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #200;
  endtask
endmodule

`default_nettype wire

// ===== accel_output_and_event_status_regs_tb.sv
// Self-checking bench for the acceleration and event status registers.
// Assumes the auxiliary master model and the package are compiled first.

`default_nettype none

module accel_output_and_event_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ODR = 800;
  localparam logic [6:0] XLO = accel_regs_pkg::ADDR_X_LO;
  localparam logic [6:0] XHI = accel_regs_pkg::ADDR_X_HI;
  localparam logic [6:0] MOT = accel_regs_pkg::ADDR_MOTION;
  localparam logic [6:0] STS = accel_regs_pkg::ADDR_STATUS;
  localparam logic [7:0] FLAG_POS [4] = '{8'h08, 8'h10, 8'h20, 8'h80};
  typedef struct {
    string name;
    logic [7:0] val;
  } exp_t;
  exp_t exp_q[$];
  int mismatches = 0;
  int num_checks = 0;
  int seed = 83561;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ui_valid = 1'b0;
  logic [15:0] ui [3] = '{default: 16'h0000};
  logic [15:0] stab [3] = '{default: 16'h0000};
  logic [3:0] motion = 4'h0;
  logic [15:0] prog = 16'h0000;
  logic [15:0] m;
  logic pri_rd = 1'b0;
  logic [6:0] pri_addr = 7'h00;
  logic [7:0] pri_data;
  logic pri_valid;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic ready;
  logic [7:0] aux_byte;
  logic aux_tog;

  always #12.5 ref_clk = ~ref_clk;

  accel_output_and_event_status_regs #(.STAB_ODR_CYCLES(ODR)) dut (
    .i_ref_clk(ref_clk), .i_resetn(resetn), .i_ui_valid(ui_valid),
    .i_ui_x(ui[0]), .i_ui_y(ui[1]), .i_ui_z(ui[2]),
    .i_stab_x(stab[0]), .i_stab_y(stab[1]), .i_stab_z(stab[2]),
    .i_motion_events(motion), .i_program_events(prog),
    .i_pri_rd(pri_rd), .i_pri_addr(pri_addr),
    .o_pri_rd_data(pri_data), .o_pri_rd_valid(pri_valid),
    .i_aux_sclk(sclk), .i_aux_cs_n(cs_n), .i_aux_mosi(mosi),
    .o_aux_miso(miso), .o_aux_miso_oe_n(miso_oe_n),
    .o_aux_sample_ready(ready)
  );

  aux_spi_master host (
    .i_miso(miso), .i_miso_oe_n(miso_oe_n), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi), .o_byte(aux_byte), .o_byte_tog(aux_tog)
  );

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(input string name, input logic [7:0] e,
                     input logic [7:0] got);
    num_checks++;
    if (got !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, e, got);
    end
  endtask

  task automatic take(input logic [7:0] got);
    exp_t e;
    if (exp_q.size() == 0)
    begin
      mismatches++;
      $display("ERROR read result expected none seen %h", got);
    end
    else
    begin
      e = exp_q.pop_front();
      chk(e.name, e.val, got);
    end
  endtask

  always @(negedge ref_clk)
    if (pri_valid === 1'b1)
      take(pri_data);

  always @(aux_tog)
    if (resetn === 1'b1)
      take(aux_byte);

  task automatic test_done;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // Stimulus helpers
  // ****************************************************************
  task automatic note(input string n, input logic [7:0] e);
    exp_q.push_back('{n, e});
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e,
                    input string n);
    note(n, e);
    pri_rd = 1'b1;
    pri_addr = a;
    @(negedge ref_clk);
  endtask

  task automatic rd_end;
    pri_rd = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic wait_ready;
    for (int n = 0; n < 2 * ODR && ready !== 1'b1; n++)
      @(negedge ref_clk);
    if (ready !== 1'b1)
    begin
      mismatches++;
      $display("ERROR sample ready expected 1 seen %b", ready);
      test_done();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset valid", 8'h00, {7'h00, pri_valid});
    chk("reset oe_n", 8'h01, {7'h00, miso_oe_n});
    chk("reset ready", 8'h00, {7'h00, ready});
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 3; i++)
    begin
      ui[i] = 16'($random(seed));
      stab[i] = ~ui[i];
    end
    ui_valid = 1'b1;
    @(negedge ref_clk);
    ui_valid = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rd(7'(XLO + 2 * i), ui[i][7:0], "ui low");
      rd(7'(XLO + 2 * i + 1), ui[i][15:8], "ui high");
    end
    rd(7'h30, 8'h00, "unmapped");
    rd(STS, 8'h00, "primary status");
    rd_end();
    repeat (ODR + 8) @(negedge ref_clk);
    for (int i = 0; i < 6; i++)
      note("aux sample", stab[i / 2][8 * (i % 2) +: 8]);
    host.xfer({1'b1, XLO}, 6, 8'h00);
    host.xfer({1'b0, XLO}, 2, 8'h5A);
    @(negedge ref_clk);
    rd(XLO, ui[0][7:0], "after write low");
    rd(XHI, ui[0][15:8], "after write high");
    rd_end();
    wait_ready();
    note("aux status", 8'h01);
    host.xfer({1'b1, STS}, 1, 8'h00);
    note("aux x low", stab[0][7:0]);
    host.xfer({1'b1, XLO}, 1, 8'h00);
    chk("ready after low", 8'h01, {7'h00, ready});
    note("aux x high", stab[0][15:8]);
    host.xfer({1'b1, XHI}, 1, 8'h00);
    repeat (8) @(negedge ref_clk);
    chk("ready after high", 8'h00, {7'h00, ready});
    for (int i = 0; i < 5; i++)
    begin
      motion = (i == 4) ? 4'hF : 4'(1 << i);
      @(negedge ref_clk);
      motion = 4'h0;
      @(negedge ref_clk);
      if (i == 4)
        rd(MOT, 8'hB8, "all motion flags");
      else
        rd(MOT, FLAG_POS[i], "motion flag");
      rd_end();
      rd(MOT, 8'h00, "motion cleared");
      rd_end();
    end
    motion = 4'h1;
    @(negedge ref_clk);
    motion = 4'h0;
    note("aux motion", 8'h08);
    host.xfer({1'b1, MOT}, 1, 8'h00);
    @(negedge ref_clk);
    rd(MOT, 8'h00, "motion after aux");
    rd_end();
    for (int i = 0; i < 5; i++)
    begin
      prog = (i == 4) ? 16'h8001 : 16'($random(seed));
      m = prog;
      @(negedge ref_clk);
      prog = 16'h0000;
      rd(accel_regs_pkg::ADDR_PROG_LO, m[7:0], "programs low");
      rd(accel_regs_pkg::ADDR_PROG_HI, m[15:8], "programs high");
      rd_end();
    end
    repeat (8) @(negedge ref_clk);
    if (exp_q.size() != 0)
    begin
      mismatches++;
      $display("ERROR pending reads expected 0 seen %0d", exp_q.size());
    end
    test_done();
  end
endmodule

`default_nettype wire
